// ==== hdl/mtd_drive_top.sv ====
// motor two drive control: pwm, encoder, tick, scan sequencer, fault latch, apb registers
`timescale 1ns/1ps
module mtd_drive_top #(
    parameter int TICK_CYCLES = mtd_pkg::TICK_CYC
) (
    // clock and shared system reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             IRQ,
    // pins from the inverter, encoder and panel
    input  wire logic        OVERCURRENT_STOP_N,
    input  wire logic        ENCODER_PHASE_A_IN,
    input  wire logic        ENCODER_PHASE_B_IN,
    input  wire logic        RUN_STOP_SWITCH,
    input  wire logic        FAULT_CLEAR_SWITCH,
    // inverter gate drive, each with its output enable
    output logic             PWM_U_UPPER,
    output logic             PWM_V_UPPER,
    output logic             PWM_W_UPPER,
    output logic             PWM_U_LOWER,
    output logic             PWM_V_LOWER,
    output logic             PWM_W_LOWER,
    output logic             PWM_U_UPPER_OE,
    output logic             PWM_V_UPPER_OE,
    output logic             PWM_W_UPPER_OE,
    output logic             PWM_U_LOWER_OE,
    output logic             PWM_V_LOWER_OE,
    output logic             PWM_W_LOWER_OE,
    // lamps
    output logic             RUN_LAMP,
    output logic             FAULT_LAMP,
    output logic             POSITION_DONE_LAMP,
    // shared interval tick
    output logic             TICK_500US,
    // converter port
    output logic             ADC_START,
    output logic [1:0]       ADC_CHAN,
    output logic             ADC_HOLD,
    input  wire logic        ADC_DONE,
    input  wire logic [11:0] ADC_DATA
);
    localparam int TW  = $clog2(TICK_CYCLES + 1);
    localparam int PW  = mtd_pkg::PWM_W;
    localparam int AW  = mtd_pkg::ADC_W;

    // synchronisers and edges
    logic [4:0] sy1_q;
    logic [4:0] sy2_q;
    logic [4:0] sy3_q;
    logic       oc_fall;
    logic       clr_rise;

    // always_ff for every concern
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            sy1_q <= mtd_pkg::SY_RST;
            sy2_q <= mtd_pkg::SY_RST;
            sy3_q <= mtd_pkg::SY_RST;
        end else begin
            sy1_q <= {FAULT_CLEAR_SWITCH, RUN_STOP_SWITCH, ENCODER_PHASE_B_IN,
                      ENCODER_PHASE_A_IN, OVERCURRENT_STOP_N};
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
        end
    end
    assign oc_fall  = sy3_q[mtd_pkg::SY_OC] & ~sy2_q[mtd_pkg::SY_OC];
    assign clr_rise = sy2_q[mtd_pkg::SY_CLR] & ~sy3_q[mtd_pkg::SY_CLR];

    // registers
    logic [1:0]             ctrl_q;
    logic [PW-1:0]          period_q;
    logic [mtd_pkg::DT_W-1:0] dead_q;
    logic [PW-1:0]          duty_q [3];
    logic [mtd_pkg::EV_N-1:0] sts_q;
    logic [mtd_pkg::EV_N-1:0] en_q;
    logic                   pready_q;
    logic                   acc;
    logic                   wr_fire;
    logic                   hit;
    logic [31:0]            rd_mux;

    assign acc     = PSEL & PENABLE;
    assign wr_fire = acc & pready_q & PWRITE;

    // one wait state gives registered read data and error
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            pready_q <= 1'b0;
            PRDATA   <= 32'h0000_0000;
            PSLVERR  <= 1'b0;
        end else begin
            pready_q <= acc & ~pready_q;
            if (acc & ~pready_q) begin
                PRDATA  <= PWRITE ? 32'h0000_0000 : rd_mux;
                PSLVERR <= ~hit;
            end else begin
                PSLVERR <= 1'b0;
            end
        end
    end
    assign PREADY = pready_q;

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            ctrl_q   <= 2'h0;
            period_q <= mtd_pkg::PERIOD_RST;
            dead_q   <= mtd_pkg::DEAD_RST;
            duty_q   <= '{default: mtd_pkg::DUTY_RST};
            en_q     <= '0;
        end else if (wr_fire) begin
            case (PADDR)
                mtd_pkg::A_CTRL:   ctrl_q    <= PWDATA[1:0];
                mtd_pkg::A_PERIOD: period_q  <= PWDATA[PW-1:0];
                mtd_pkg::A_DEAD:   dead_q    <= PWDATA[mtd_pkg::DT_W-1:0];
                mtd_pkg::A_DUTY_U: duty_q[0] <= PWDATA[PW-1:0];
                mtd_pkg::A_DUTY_V: duty_q[1] <= PWDATA[PW-1:0];
                mtd_pkg::A_DUTY_W: duty_q[2] <= PWDATA[PW-1:0];
                mtd_pkg::A_IRQ_EN: en_q      <= PWDATA[mtd_pkg::EV_N-1:0];
                default: ;
            endcase
        end
    end

    // carrier, legs, pins
    logic [PW-1:0] cnt_q;
    logic          down_q;
    logic          trig;
    logic [2:0]    up_on;
    logic [2:0]    lo_on;
    logic [2:0]    up_q;
    logic [2:0]    lo_q;
    logic          oe_q;
    logic          run_q;
    logic          fault_q;
    logic          short_det;
    logic          fault_set;

    // triangle carrier, the valley is the converter trigger
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            cnt_q  <= '0;
            down_q <= 1'b0;
        end else if (!down_q) begin
            if (cnt_q >= period_q) begin
                down_q <= 1'b1;
                if (cnt_q != '0) cnt_q <= cnt_q - 1'b1;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end else if (cnt_q == '0) begin
            down_q <= 1'b0;
            cnt_q  <= cnt_q + 1'b1;
        end else begin
            cnt_q <= cnt_q - 1'b1;
        end
    end
    assign trig = (cnt_q == '0);

    for (genvar i = 0; i < 3; i++) begin : g_leg
        mtd_pwm_leg #(.DT_W(mtd_pkg::DT_W)) u_leg (
            .clk     (CORE_CLK),
            .rst_n   (RST_N),
            .ref_hi  (cnt_q < duty_q[i]),
            .dead    (dead_q),
            .up_on_q (up_on[i]),
            .lo_on_q (lo_on[i])
        );
    end

    // run needs software enable, the toggle switch and no latched fault
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            run_q <= 1'b0;
        end else begin
            run_q <= ctrl_q[mtd_pkg::CTRL_EN] & sy2_q[mtd_pkg::SY_RUN] & ~fault_q;
        end
    end

    // pins stopped without a latched fault rest in the off level rather than floating
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            up_q <= 3'h7;
            lo_q <= 3'h0;
            oe_q <= 1'b0;
        end else begin
            up_q <= run_q ? ~up_on : 3'h7;
            lo_q <= run_q ? lo_on : 3'h0;
            oe_q <= ~fault_q;
        end
    end
    assign {PWM_W_UPPER, PWM_V_UPPER, PWM_U_UPPER} = up_q;
    assign {PWM_W_LOWER, PWM_V_LOWER, PWM_U_LOWER} = lo_q;
    assign {PWM_U_UPPER_OE, PWM_V_UPPER_OE, PWM_W_UPPER_OE} = {3{oe_q}};
    assign {PWM_U_LOWER_OE, PWM_V_LOWER_OE, PWM_W_LOWER_OE} = {3{oe_q}};

    // both switches of one leg on at once means the outputs are shorted
    assign short_det = oe_q & (|(~up_q & lo_q));
    assign fault_set = oc_fall | short_det;

    // a new fault wins over a clear in the same cycle
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            fault_q <= 1'b0;
        end else if (fault_set) begin
            fault_q <= 1'b1;
        end else if (clr_rise) begin
            fault_q <= 1'b0;
        end
    end

    // lamps
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            RUN_LAMP           <= 1'b0;
            FAULT_LAMP         <= 1'b0;
            POSITION_DONE_LAMP <= 1'b0;
        end else begin
            RUN_LAMP           <= run_q;
            FAULT_LAMP         <= fault_q;
            POSITION_DONE_LAMP <= ctrl_q[mtd_pkg::CTRL_POS];
        end
    end

    // interval tick, also driven out for the other motor controllers
    logic [TW-1:0] tick_cnt_q;
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            tick_cnt_q <= '0;
            TICK_500US <= 1'b0;
        end else if (tick_cnt_q == TW'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= '0;
            TICK_500US <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
            TICK_500US <= 1'b0;
        end
    end

    // speed time base wraps freely, software takes differences
    logic [mtd_pkg::SPD_W-1:0] spd_q;
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) spd_q <= '0;
        else spd_q <= spd_q + 1'b1;
    end

    logic [mtd_pkg::ENC_W-1:0] enc_cnt;
    mtd_quad_count #(.W(mtd_pkg::ENC_W)) u_enc (
        .clk      (CORE_CLK),
        .rst_n    (RST_N),
        .ph_a     (sy2_q[mtd_pkg::SY_A]),
        .ph_b     (sy2_q[mtd_pkg::SY_B]),
        .load     (wr_fire && PADDR == mtd_pkg::A_ENC),
        .load_val (PWDATA[mtd_pkg::ENC_W-1:0]),
        .cnt_q    (enc_cnt)
    );

    // scan sequencer: U and W under common hold, then bus voltage, then reference
    mtd_pkg::mtd_adc_t adc_st_q;
    logic [AW-1:0]     res_q [4];
    logic              scan_done_q;
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            adc_st_q    <= mtd_pkg::ADC_IDLE;
            ADC_CHAN    <= mtd_pkg::CH_CURRENT_U_SENSE;
            ADC_START   <= 1'b0;
            ADC_HOLD    <= 1'b0;
            scan_done_q <= 1'b0;
            res_q       <= '{default: '0};
        end else begin
            ADC_START   <= 1'b0;
            scan_done_q <= 1'b0;
            case (adc_st_q)
                mtd_pkg::ADC_IDLE: begin
                    if (trig) begin
                        adc_st_q  <= mtd_pkg::ADC_CONV;
                        ADC_HOLD  <= 1'b1;
                        ADC_CHAN  <= mtd_pkg::CH_CURRENT_U_SENSE;
                        ADC_START <= 1'b1;
                    end
                end
                mtd_pkg::ADC_CONV: begin
                    if (ADC_DONE && !ADC_START) begin
                        res_q[ADC_CHAN] <= ADC_DATA;
                        if (ADC_CHAN == mtd_pkg::CH_CURRENT_W_SENSE) ADC_HOLD <= 1'b0;
                        if (ADC_CHAN == mtd_pkg::CH_REFERENCE_SENSE) begin
                            adc_st_q    <= mtd_pkg::ADC_IDLE;
                            scan_done_q <= 1'b1;
                        end else begin
                            ADC_CHAN  <= ADC_CHAN + 1'b1;
                            ADC_START <= 1'b1;
                        end
                    end
                end
                default: adc_st_q <= mtd_pkg::ADC_IDLE;
            endcase
        end
    end

    // sticky events, set beats clear
    logic [mtd_pkg::EV_N-1:0] ev;
    logic [mtd_pkg::EV_N-1:0] clr_mask;
    assign ev = {fault_set, scan_done_q, TICK_500US};
    assign clr_mask = (wr_fire && PADDR == mtd_pkg::A_IRQ_CLR) ? PWDATA[mtd_pkg::EV_N-1:0] : '0;
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            sts_q <= '0;
            IRQ   <= 1'b0;
        end else begin
            sts_q <= (sts_q & ~clr_mask) | ev;
            IRQ   <= |(sts_q & en_q);
        end
    end

    // read mux
    always_comb begin
        rd_mux = 32'h0000_0000;
        hit    = 1'b1;
        case (PADDR)
            mtd_pkg::A_CTRL:    rd_mux[1:0]    = ctrl_q;
            mtd_pkg::A_PERIOD:  rd_mux[PW-1:0] = period_q;
            mtd_pkg::A_DEAD:    rd_mux[mtd_pkg::DT_W-1:0] = dead_q;
            mtd_pkg::A_DUTY_U:  rd_mux[PW-1:0] = duty_q[0];
            mtd_pkg::A_DUTY_V:  rd_mux[PW-1:0] = duty_q[1];
            mtd_pkg::A_DUTY_W:  rd_mux[PW-1:0] = duty_q[2];
            mtd_pkg::A_ENC:     rd_mux[mtd_pkg::ENC_W-1:0] = enc_cnt;
            mtd_pkg::A_SPEED:   rd_mux[mtd_pkg::SPD_W-1:0] = spd_q;
            mtd_pkg::A_ADC_IUW: rd_mux = {4'h0, res_q[1], 4'h0, res_q[0]};
            mtd_pkg::A_ADC_VR:  rd_mux = {4'h0, res_q[3], 4'h0, res_q[2]};
            mtd_pkg::A_STATUS: begin
                rd_mux[mtd_pkg::ST_FAULT] = fault_q;
                rd_mux[mtd_pkg::ST_RUN]   = run_q;
                rd_mux[mtd_pkg::ST_RUNSW] = sy2_q[mtd_pkg::SY_RUN];
                rd_mux[mtd_pkg::ST_CLRSW] = sy2_q[mtd_pkg::SY_CLR];
                rd_mux[mtd_pkg::ST_HOLD]  = ADC_HOLD;
            end
            mtd_pkg::A_IRQ_STS: rd_mux[mtd_pkg::EV_N-1:0] = sts_q;
            mtd_pkg::A_IRQ_CLR: rd_mux = 32'h0000_0000;
            mtd_pkg::A_IRQ_EN:  rd_mux[mtd_pkg::EV_N-1:0] = en_q;
            default:            hit = 1'b0;
        endcase
    end

    // checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    a_leg_overlap:
        assert property (oe_q |-> (~up_q & lo_q) == 3'h0) else $error("leg switches on together");
    a_idle_level:
        assert property (!run_q |=> up_q == 3'h7 && lo_q == 3'h0) else $error("stopped pins not at off level");
    a_enc_step:
        assert property (u_enc.step && !u_enc.load && u_enc.up |=> enc_cnt == $past(enc_cnt) + 1'b1)
        else $error("encoder did not count up");
    a_oc_float:
        assert property (oc_fall |=> ##1 !oe_q) else $error("overcurrent did not float outputs");
    a_short_float:
        assert property (short_det |=> fault_q ##1 !oe_q) else $error("short did not float outputs");
    a_tick_gap:
        assert property (TICK_500US |=> !TICK_500US [*8]) else $error("tick too frequent");
    a_scan_start:
        assert property (RST_N && trig && adc_st_q == mtd_pkg::ADC_IDLE |=> ADC_START && ADC_HOLD && ADC_CHAN == 2'h0)
        else $error("scan not started on trigger");
    a_hold_span:
        assert property (ADC_CHAN == 2'h2 && $past(ADC_CHAN) == 2'h1 |-> $fell(ADC_HOLD))
        else $error("hold released at wrong channel");
    a_speed_free:
        assert property ($past(RST_N) |-> spd_q == $past(spd_q) + 1'b1) else $error("speed timer not free running");
    a_run_lamp:
        assert property (##1 RUN_LAMP == $past(run_q)) else $error("run lamp wrong");
    a_fault_lamp:
        assert property (fault_set |=> ##1 FAULT_LAMP) else $error("fault lamp not lit");
    a_fault_latch:
        assert property (fault_q && !clr_rise |=> fault_q) else $error("fault dropped without clear");
    a_fault_clear:
        assert property (clr_rise && !fault_set |=> !fault_q) else $error("fault clear ignored");
endmodule : mtd_drive_top

// ==== inc/mtd_pkg.sv ====
// constants, register map and types for the motor two drive control block
//
// Overview of operation
// - complementary phase outputs with dead time inserted
// - upper outputs active low, lower active high
// - encoder count direction from A/B phase
// - over-current falling edge floats all six outputs
// - output short between phase pins floats outputs
// - shared interval tick every 500 us
// - hardware-triggered single scan of four inputs
// - U and W currents held at one instant
// - free-running speed measurement timer, never reloaded
// - run lamp lit while motor rotates
// - fault lamp lit while error present
// - position lamp lit when positioning complete
// - fault clear switch returns to normal operation
// - system reset clears all motor controllers
// - reference potentiometer digitized within the scan
package mtd_pkg;
    localparam int CLK_HZ       = 40_000_000;
    localparam int TICK_US      = 500;
    localparam int TICK_CYC     = CLK_HZ / 1_000_000 * TICK_US;
    localparam int PWM_W        = 16;
    localparam int DT_W         = 8;
    localparam int ENC_W        = 16;
    localparam int SPD_W        = 16;
    localparam int ADC_W        = 12;
    localparam int EV_N         = 3;
    // register byte offsets
    localparam logic [7:0] A_CTRL    = 8'h00;
    localparam logic [7:0] A_PERIOD  = 8'h04;
    localparam logic [7:0] A_DEAD    = 8'h08;
    localparam logic [7:0] A_DUTY_U  = 8'h0C;
    localparam logic [7:0] A_DUTY_V  = 8'h10;
    localparam logic [7:0] A_DUTY_W  = 8'h14;
    localparam logic [7:0] A_ENC     = 8'h18;
    localparam logic [7:0] A_SPEED   = 8'h1C;
    localparam logic [7:0] A_ADC_IUW = 8'h20;
    localparam logic [7:0] A_ADC_VR  = 8'h24;
    localparam logic [7:0] A_STATUS  = 8'h28;
    localparam logic [7:0] A_IRQ_STS = 8'h2C;
    localparam logic [7:0] A_IRQ_CLR = 8'h30;
    localparam logic [7:0] A_IRQ_EN  = 8'h34;
    // reset values
    localparam logic [PWM_W-1:0] PERIOD_RST = 16'h03E8;
    localparam logic [DT_W-1:0]  DEAD_RST   = 8'h50;
    localparam logic [PWM_W-1:0] DUTY_RST   = 16'h01F4;
    // field positions
    localparam int CTRL_EN   = 0;
    localparam int CTRL_POS  = 1;
    localparam int ST_FAULT  = 0;
    localparam int ST_RUN    = 1;
    localparam int ST_RUNSW  = 2;
    localparam int ST_CLRSW  = 3;
    localparam int ST_HOLD   = 4;
    localparam int EV_TICK   = 0;
    localparam int EV_ADC    = 1;
    localparam int EV_FAULT  = 2;
    // synchroniser lanes
    localparam int SY_OC  = 0;
    localparam int SY_A   = 1;
    localparam int SY_B   = 2;
    localparam int SY_RUN = 3;
    localparam int SY_CLR = 4;
    localparam logic [4:0] SY_RST = 5'h01;
    // converter channels in scan order
    localparam logic [1:0] CH_CURRENT_U_SENSE  = 2'h0;
    localparam logic [1:0] CH_CURRENT_W_SENSE  = 2'h1;
    localparam logic [1:0] CH_BUS_VOLTAGE_SENSE = 2'h2;
    localparam logic [1:0] CH_REFERENCE_SENSE  = 2'h3;
    typedef enum logic {ADC_IDLE = 1'b0, ADC_CONV = 1'b1} mtd_adc_t;
endpackage : mtd_pkg

// ==== hdl/mtd_pwm_leg.sv ====
// one inverter leg: complementary drive pair with dead time
`timescale 1ns/1ps
module mtd_pwm_leg #(
    parameter int DT_W = 8
) (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            rst_n,
    // control
    input  wire logic            ref_hi,
    input  wire logic [DT_W-1:0] dead,
    // switch requests, active high
    output logic                 up_on_q,
    output logic                 lo_on_q
);
    logic            cur_q;
    logic [DT_W-1:0] dcnt_q;

    // on every change of the reference both switches go off for the dead time first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cur_q   <= 1'b0;
            dcnt_q  <= '0;
            up_on_q <= 1'b0;
            lo_on_q <= 1'b0;
        end else if (ref_hi != cur_q) begin
            cur_q   <= ref_hi;
            up_on_q <= 1'b0;
            lo_on_q <= 1'b0;
            dcnt_q  <= dead;
        end else if (dcnt_q != '0) begin
            dcnt_q <= dcnt_q - 1'b1;
        end else begin
            up_on_q <= cur_q;
            lo_on_q <= ~cur_q;
        end
    end
endmodule : mtd_pwm_leg

// ==== hdl/mtd_quad_count.sv ====
// quadrature encoder up/down counter with software load
`timescale 1ns/1ps
module mtd_quad_count #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // synchronised encoder phases
    input  wire logic         ph_a,
    input  wire logic         ph_b,
    // load port
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    // count
    output logic [W-1:0]      cnt_q
);
    logic a_q;
    logic b_q;
    logic step;
    logic up;

    // a change on both phases at once is a lost step and is dropped
    assign step = (ph_a ^ a_q) ^ (ph_b ^ b_q);
    assign up   = ph_a ^ b_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            a_q   <= 1'b0;
            b_q   <= 1'b0;
            cnt_q <= '0;
        end else begin
            a_q <= ph_a;
            b_q <= ph_b;
            if (load) begin
                cnt_q <= load_val;
            end else if (step) begin
                cnt_q <= up ? cnt_q + 1'b1 : cnt_q - 1'b1;
            end
        end
    end
endmodule : mtd_quad_count

// ==== test/mtd_adc_far.sv ====
// converter model on the far side: answers each start, alternating fast and slow
`timescale 1ns/1ps
module mtd_adc_far (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // conversion request
    input  wire logic        start,
    input  wire logic [1:0]  chan,
    input  wire logic        hold,
    input  wire logic [11:0] base,
    // result and hold monitor
    output logic             done,
    output logic [11:0]      data,
    output logic             hold_bad
);
    logic [2:0] wait_q;
    logic [1:0] ch_q;
    logic       busy_q;
    logic       slow_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_q   <= 1'b0;
            slow_q   <= 1'b0;
            wait_q   <= 3'h0;
            ch_q     <= 2'h0;
            done     <= 1'b0;
            data     <= 12'hFFF;
            hold_bad <= 1'b0;
        end else begin
            done <= 1'b0;
            // released bus does not keep the last result
            if (done) data <= ~data;
            if (start) begin
                busy_q <= 1'b1;
                ch_q   <= chan;
                wait_q <= slow_q ? 3'h5 : 3'h1;
                slow_q <= ~slow_q;
                if (chan < 2'h2 && !hold) hold_bad <= 1'b1;
            end else if (busy_q) begin
                if (wait_q == 3'h0) begin
                    busy_q <= 1'b0;
                    done   <= 1'b1;
                    data   <= base ^ {10'h0, ch_q};
                end else begin
                    wait_q <= wait_q - 3'h1;
                end
            end
        end
    end
endmodule : mtd_adc_far

// ==== test/tb.sv ====
// self-checking bench for the motor two drive control block
`timescale 1ns/1ps
module tb;
    localparam int TICKS = 50;
    localparam logic [7:0] GRAY = 8'h2D;
    logic        CORE_CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd, s1, seed = 96938;
    logic        OC_N = 1, ENC_A = 0, ENC_B = 0, RUN_SW = 0, CLR_SW = 0, err;
    logic        PREADY, PSLVERR, IRQ, TICK, ADC_START, ADC_HOLD, ADC_DONE, hold_bad;
    logic [1:0]  ADC_CHAN;
    logic [11:0] ADC_DATA, base;
    logic [2:0]  up, lo, oe_up, oe_lo, lamp, seen_up = 0, seen_lo = 0;
    int          n_fail = 0, comparisons = 0, i, k, enc_pos = 0;
    always #12.5 CORE_CLK = ~CORE_CLK;
    mtd_drive_top #(.TICK_CYCLES(TICKS)) u_dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ), .OVERCURRENT_STOP_N(OC_N),
        .ENCODER_PHASE_A_IN(ENC_A), .ENCODER_PHASE_B_IN(ENC_B), .RUN_STOP_SWITCH(RUN_SW),
        .FAULT_CLEAR_SWITCH(CLR_SW), .PWM_U_UPPER(up[0]), .PWM_V_UPPER(up[1]), .PWM_W_UPPER(up[2]),
        .PWM_U_LOWER(lo[0]), .PWM_V_LOWER(lo[1]), .PWM_W_LOWER(lo[2]), .PWM_U_UPPER_OE(oe_up[0]),
        .PWM_V_UPPER_OE(oe_up[1]), .PWM_W_UPPER_OE(oe_up[2]), .PWM_U_LOWER_OE(oe_lo[0]),
        .PWM_V_LOWER_OE(oe_lo[1]), .PWM_W_LOWER_OE(oe_lo[2]), .RUN_LAMP(lamp[0]),
        .FAULT_LAMP(lamp[1]), .POSITION_DONE_LAMP(lamp[2]), .TICK_500US(TICK), .ADC_START(ADC_START),
        .ADC_CHAN(ADC_CHAN), .ADC_HOLD(ADC_HOLD), .ADC_DONE(ADC_DONE), .ADC_DATA(ADC_DATA));
    mtd_adc_far u_far (.clk(CORE_CLK), .rst_n(RST_N), .start(ADC_START), .chan(ADC_CHAN),
        .hold(ADC_HOLD), .base(base), .done(ADC_DONE), .data(ADC_DATA), .hold_bad(hold_bad));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge CORE_CLK);
    endtask : cyc
    // holds the request until pready is sampled high at a rising edge; only the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge CORE_CLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= wd;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        do @(posedge CORE_CLK); while (PREADY !== 1'b1);
        rd  = PRDATA;
        err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic step(input bit fwd);
        enc_pos = fwd ? enc_pos + 1 : enc_pos - 1;
        @(posedge CORE_CLK);
        {ENC_A, ENC_B} <= GRAY[7 - 2 * (enc_pos & 3) -: 2];
        cyc(4);
    endtask : step
    task automatic wait_tick();
        for (i = 0; i < 1000; i++) begin
            @(negedge CORE_CLK);
            if (TICK === 1'b1) break;
        end
    endtask : wait_tick
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    always @(negedge CORE_CLK) begin
        if (RST_N === 1'b1) begin
            if ((~up & lo & oe_up) !== 3'h0) chk("leg_overlap", ~up & lo, 0);
            seen_up |= ~up & oe_up;
            seen_lo |= lo & oe_lo;
        end
    end
    initial begin
        repeat (40000) @(posedge CORE_CLK);
        n_fail++;
        print_verdict();
    end
    initial begin
        s1   = xs();
        base = s1[11:0];
        repeat (6) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        cyc(2);
        chk("idle_pins", {up, lo}, 6'h38);
        apb(0, mtd_pkg::A_PERIOD, 0);
        chk("period", rd, 32'h3E8);
        apb(0, 8'h3C, 0);
        chk("unmapped", {err, rd}, 33'h100000000);
        $display("test reset done");
        k = 4 * int'(xs() % 3) + 7;
        for (int n = 0; n < k; n++) step(1);
        for (int n = 0; n < 3; n++) step(0);
        apb(0, mtd_pkg::A_ENC, 0);
        chk("enc_count", rd, 32'(k - 3));
        $display("test encoder done");
        apb(1, mtd_pkg::A_IRQ_EN, 1);
        wait_tick();
        wait_tick();
        chk("tick_gap", 32'(i + 1), TICKS);
        cyc(2);
        chk("irq_on", IRQ, 1);
        apb(1, mtd_pkg::A_IRQ_EN, 0);
        cyc(2);
        chk("irq_masked", IRQ, 0);
        wait_tick();
        apb(1, mtd_pkg::A_IRQ_CLR, 7);
        apb(0, mtd_pkg::A_IRQ_STS, 0);
        chk("tick_cleared", rd[0], 0);
        $display("test tick done");
        apb(1, mtd_pkg::A_PERIOD, 20);
        apb(1, mtd_pkg::A_DEAD, 3);
        for (int n = 0; n < 3; n++) apb(1, mtd_pkg::A_DUTY_U + 8'(4 * n), xs() % 14 + 4);
        apb(1, mtd_pkg::A_CTRL, 3);
        @(posedge CORE_CLK);
        RUN_SW <= 1'b1;
        cyc(200);
        chk("run_lamps", lamp, 3'h5);
        chk("both_sides", {seen_up, seen_lo}, 6'h3F);
        for (k = 0; k < 40; k++) begin
            apb(0, mtd_pkg::A_IRQ_STS, 0);
            if (rd[mtd_pkg::EV_ADC] === 1'b1) break;
        end
        chk("scan_done", rd[mtd_pkg::EV_ADC], 1);
        apb(0, mtd_pkg::A_ADC_IUW, 0);
        chk("currents", rd, {4'h0, base ^ 12'h1, 4'h0, base});
        apb(0, mtd_pkg::A_ADC_VR, 0);
        chk("ref_vdc", rd, {4'h0, base ^ 12'h3, 4'h0, base ^ 12'h2});
        chk("hold", hold_bad, 0);
        apb(0, mtd_pkg::A_SPEED, 0);
        s1 = rd;
        apb(0, mtd_pkg::A_SPEED, 0);
        chk("speed_runs", 16'(rd - s1), 16'h4);
        $display("test run done");
        @(posedge CORE_CLK);
        OC_N <= 1'b0;
        cyc(8);
        chk("float", {oe_up, oe_lo, lamp[1]}, 1);
        @(posedge CORE_CLK);
        OC_N <= 1'b1;
        cyc(20);
        chk("latched", {oe_up, oe_lo, lamp[1]}, 1);
        @(posedge CORE_CLK);
        CLR_SW <= 1'b1;
        cyc(6);
        @(posedge CORE_CLK);
        CLR_SW <= 1'b0;
        cyc(8);
        chk("recover", {oe_up, oe_lo, lamp[1]}, 7'h7E);
        $display("test fault done");
        @(posedge CORE_CLK);
        RST_N <= 1'b0;
        cyc(2);
        chk("rst_float", {oe_up, oe_lo, lamp}, 0);
        @(posedge CORE_CLK);
        RST_N <= 1'b1;
        cyc(2);
        apb(0, mtd_pkg::A_ENC, 0);
        chk("enc_rst", rd, 0);
        $display("test system reset done");
        print_verdict();
    end
endmodule : tb
